// ===== design/misc_slice_pkg.sv
// Constants shared by the runtime miscellaneous register slice.
package misc_slice_pkg;

    // ------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_EN = 8'h1a;
    localparam logic [7:0] IDX_RSVD_A = 8'h1b;
    localparam logic [7:0] IDX_STS = 8'h1c;
    localparam logic [7:0] IDX_RSVD_B = 8'h1d;
    localparam logic [7:0] IDX_FORCE = 8'h1e;
    localparam logic [7:0] IDX_RATE = 8'h1f;
    localparam logic [7:0] IDX_SER1 = 8'h20;
    localparam logic [7:0] IDX_SER2 = 8'h21;

    // ------------------------------------------------------------
    // Reset values and implemented-bit masks.
    // ------------------------------------------------------------
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [5:0] STS_RESET = 6'h00;
    localparam logic [1:0] FORCE_RESET = 2'h1;
    localparam logic [7:0] SHADOW_RESET = 8'h00;
    localparam logic [7:0] EN_MASK = 8'hcf;
    localparam logic [7:0] RATE_MASK = 8'hdf;
    localparam logic [7:0] QUEUE_MASK = 8'hcf;

    // ------------------------------------------------------------
    // Bus encodings.
    // ------------------------------------------------------------
    localparam int unsigned HTRANS_ACTIVE_BIT = 1;
    localparam int unsigned DATA_W = 32;

endpackage

// ===== design/misc_slice.sv
// Runtime miscellaneous register slice with an AHB-Lite register port.
`timescale 1ns/1ns
module misc_slice #(
    parameter int unsigned ADDR_W = 10
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic main_rst_n_i,
    input wire logic hsel_i,
    input wire logic [ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [misc_slice_pkg::DATA_W-1:0] hwdata_i,
    input wire logic hready_i,
    output logic [misc_slice_pkg::DATA_W-1:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic general_pin_54_i,
    input wire logic general_pin_55_i,
    input wire logic general_pin_56_i,
    input wire logic general_pin_57_i,
    input wire logic fan_speed_sense_1_i,
    input wire logic fan_speed_sense_2_i,
    output logic grouped_mgmt_irq_out_n_o,
    input wire logic general_pin_21_i,
    input wire logic general_pin_22_i,
    input wire logic general_pin_41_i,
    input wire logic general_pin_43_i,
    input wire logic general_pin_60_i,
    input wire logic general_pin_61_i,
    input wire logic head_step_pulse_n_i,
    input wire logic drive_select_0_n_i,
    input wire logic drive_select_1_n_i,
    input wire logic media_changed_input_n_i,
    output logic media_changed_o,
    input wire logic rate_wr_i,
    input wire logic [7:0] rate_data_i,
    input wire logic serial1_queue_wr_i,
    input wire logic [7:0] serial1_queue_data_i,
    input wire logic serial2_queue_wr_i,
    input wire logic [7:0] serial2_queue_data_i
);
    import misc_slice_pkg::*;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic ph_wr;
    logic ph_rd;
    logic [7:0] ph_idx;
    logic rd_done;
    logic addr_take;
    logic wr_en;
    logic wr_sts;
    logic wr_force;
    logic [7:0] wdat;
    logic [7:0] rd_mux;

    // Registers and internal state.
    logic [7:0] mgmt_irq_enable_five;
    logic [5:0] edge_event_status;
    logic [1:0] forced_media_change;
    logic [7:0] floppy_rate_mirror;
    logic [7:0] serial1_queue_ctrl_mirror;
    logic [7:0] serial2_queue_ctrl_mirror;
    logic [5:0] pin_now;
    logic [5:0] pin_prev;
    logic prev_ok;
    logic [5:0] edge_hit;
    logic [7:0] irq_src;
    logic [1:0] step_clr;
    logic [1:0] force_set;
    logic next_media;
    logic irq_any;

    // An address phase is taken only while the bus is ready.
    assign addr_take = hsel_i && htrans_i[HTRANS_ACTIVE_BIT] && hready_i;
    assign hresp_o = 1'b0;
    // Reads stall one cycle so that read data always comes from a flop.
    assign hreadyout_o = !(ph_rd && !rd_done);

    // Address phase capture.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_idx <= 8'h00;
        end
        else if (hready_i)
        begin
            ph_wr <= addr_take && hwrite_i;
            ph_rd <= addr_take && !hwrite_i;
            ph_idx <= {2'b00, haddr_i[7:2]};
        end
    end

    // Wait-state tracker for read data phases.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            rd_done <= 1'b0;
        else if (hready_i)
            rd_done <= 1'b0;
        else if (ph_rd)
            rd_done <= 1'b1;
    end

    // Write strobes; a write data phase always lasts one cycle.
    // Upper address bits must be zero for a hit; other addresses are ignored.
    assign wdat = hwdata_i[7:0];
    logic hi_zero;
    logic [ADDR_W-1:0] haddr_q_hi;
    assign hi_zero = (ADDR_W <= 8) || (haddr_q_hi == '0);
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            haddr_q_hi <= '0;
        else if (hready_i)
            haddr_q_hi <= haddr_i >> 8;
    end
    assign wr_en = ph_wr && hi_zero && (ph_idx == IDX_EN);
    assign wr_sts = ph_wr && hi_zero && (ph_idx == IDX_STS);
    assign wr_force = ph_wr && hi_zero && (ph_idx == IDX_FORCE);

    // Read multiplexer; reserved and unmapped offsets read zero.
    always_comb
    begin
        rd_mux = 8'h00;
        if (hi_zero)
        begin
            unique case (ph_idx)
                IDX_EN: rd_mux = mgmt_irq_enable_five;
                IDX_STS: rd_mux = {2'b00, edge_event_status};
                IDX_FORCE: rd_mux = {6'h00, forced_media_change};
                IDX_RATE: rd_mux = floppy_rate_mirror;
                IDX_SER1: rd_mux = serial1_queue_ctrl_mirror;
                IDX_SER2: rd_mux = serial2_queue_ctrl_mirror;
                default: rd_mux = 8'h00;
            endcase
        end
    end

    // Read data is loaded in the stalled cycle and held afterwards.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            hrdata_o <= '0;
        else if (ph_rd && !rd_done)
            hrdata_o <= {24'h000000, rd_mux};
    end

    // ------------------------------------------------------------
    // Interrupt enable and grouped output
    // ------------------------------------------------------------
    assign irq_src = {fan_speed_sense_2_i, fan_speed_sense_1_i, 2'b00, general_pin_57_i,
                      general_pin_56_i, general_pin_55_i, general_pin_54_i};
    // Any enabled source that is active at present.
    assign irq_any = |(mgmt_irq_enable_five & irq_src);

    // Enable register; reserved bits 5:4 are not stored.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            mgmt_irq_enable_five <= EN_RESET;
        else if (wr_en)
            mgmt_irq_enable_five <= wdat & EN_MASK;
    end

    // Grouped output is driven low while any enabled source is active.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            grouped_mgmt_irq_out_n_o <= 1'b1;
        else
            grouped_mgmt_irq_out_n_o <= !irq_any;
    end

    // ------------------------------------------------------------
    // Either-edge status
    // ------------------------------------------------------------
    assign pin_now = {general_pin_61_i, general_pin_60_i, general_pin_43_i,
                      general_pin_41_i, general_pin_22_i, general_pin_21_i};
    // No edge is reported until a first sample exists after reset.
    assign edge_hit = prev_ok ? (pin_now ^ pin_prev) : 6'h00;

    // Previous pin levels.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            pin_prev <= 6'h00;
            prev_ok <= 1'b0;
        end
        else
        begin
            pin_prev <= pin_now;
            prev_ok <= 1'b1;
        end
    end

    // Sticky status; a new edge wins over a same-cycle clear.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            edge_event_status <= STS_RESET;
        else
            edge_event_status <= (edge_event_status & ~(wr_sts ? wdat[5:0] : 6'h00))
                                 | edge_hit;
    end

    // ------------------------------------------------------------
    // Forced disk change
    // ------------------------------------------------------------
    assign force_set = wr_force ? wdat[1:0] : 2'b00;
    assign step_clr = {!head_step_pulse_n_i && !drive_select_1_n_i,
                       !head_step_pulse_n_i && !drive_select_0_n_i};

    // Set-only from software; a software set wins over a step clear.
    always_ff @(posedge ref_clk_i)
    begin
        if (!main_rst_n_i)
            forced_media_change <= FORCE_RESET;
        else
            forced_media_change <= (forced_media_change & ~step_clr)
                                   | force_set;
    end

    // Disk-change flag seen by the floppy input register bit 7.
    assign next_media = (!drive_select_0_n_i && forced_media_change[0])
                        || (!drive_select_1_n_i && forced_media_change[1])
                        || !media_changed_input_n_i;
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            media_changed_o <= 1'b0;
        else
            media_changed_o <= next_media;
    end

    // ------------------------------------------------------------
    // Read-only mirrors of write-only control registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            floppy_rate_mirror <= SHADOW_RESET;
        else if (rate_wr_i)
            floppy_rate_mirror <= rate_data_i & RATE_MASK;
    end

    // Serial port 1 queue control mirror.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            serial1_queue_ctrl_mirror <= SHADOW_RESET;
        else if (serial1_queue_wr_i)
            serial1_queue_ctrl_mirror <= serial1_queue_data_i & QUEUE_MASK;
    end

    // Serial port 2 queue control mirror.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            serial2_queue_ctrl_mirror <= SHADOW_RESET;
        else if (serial2_queue_wr_i)
            serial2_queue_ctrl_mirror <= serial2_queue_data_i & QUEUE_MASK;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Output follows enabled sources one cycle later.
    irq_route_a: assert property (
        1 |=> (grouped_mgmt_irq_out_n_o == !$past(irq_any)))
        else $error("grouped interrupt output does not follow enabled sources");

    // Reserved offsets read zero.
    rsvd_read_a: assert property (
        (ph_rd && !rd_done && (ph_idx == IDX_RSVD_A || ph_idx == IDX_RSVD_B))
        |=> (hrdata_o == '0) && hreadyout_o)
        else $error("reserved offset read nonzero");

    // Write-one clears without a fresh edge.
    w1c_clear_a: assert property (
        wr_sts |=> ((edge_event_status & $past(wdat[5:0]) & ~$past(edge_hit)) == 6'h00))
        else $error("status bit not cleared by write of one");

    // Edges latch.
    edge_latch_a: assert property (
        (|edge_hit) |=> ((edge_event_status & $past(edge_hit)) == $past(edge_hit)))
        else $error("pin edge not latched in status");

    // Status upper bits read zero.
    sts_upper_a: assert property (
        (ph_rd && !rd_done && ph_idx == IDX_STS) |=> (hrdata_o[7:6] == 2'b00))
        else $error("status bits 7:6 not zero");

    // Software cannot clear a forced bit.
    force_hold_a: assert property (
        (main_rst_n_i && forced_media_change[0] && !step_clr[0]) |=> forced_media_change[0])
        else $error("forced change bit cleared without step");

    // Step with select clears.
    step_clear_a: assert property (
        (main_rst_n_i && step_clr[1] && !force_set[1]) |=> !forced_media_change[1])
        else $error("step with select did not clear forced change");

    // Disk-change flag is the three-term OR.
    media_or_a: assert property (
        1 |=> (media_changed_o == $past(next_media)))
        else $error("disk change flag mismatch");

    // Main reset loads one.
    force_reset_a: assert property (
        !main_rst_n_i |=> (forced_media_change == FORCE_RESET))
        else $error("forced change reset value wrong");

    // Standby reset clears enable and status.
    standby_reset_a: assert property (@(posedge ref_clk_i) disable iff (1'b0)
        !rst_n_i |=> (mgmt_irq_enable_five == 8'h00 && edge_event_status == 6'h00))
        else $error("standby reset values wrong");

    // Rate mirror captures writes, masked by RATE_MASK.
    rate_mirror_a: assert property (
        rate_wr_i |=> (floppy_rate_mirror == ($past(rate_data_i) & RATE_MASK)))
        else $error("rate mirror capture wrong");

    // Serial 1 mirror capture.
    ser1_mirror_a: assert property (
        serial1_queue_wr_i |=> (serial1_queue_ctrl_mirror[5:4] == 2'b00)
        && (serial1_queue_ctrl_mirror == ($past(serial1_queue_data_i) & QUEUE_MASK)))
        else $error("serial 1 mirror capture wrong");

    // Serial 2 mirror capture.
    ser2_mirror_a: assert property (
        serial2_queue_wr_i |=> (serial2_queue_ctrl_mirror
        == ($past(serial2_queue_data_i) & QUEUE_MASK)))
        else $error("serial 2 mirror capture wrong");

    // Rate and serial 1 mirrors hold when not written, reads included.
    mirror_hold_a: assert property (
        (!rate_wr_i && !serial1_queue_wr_i) |=> $stable(floppy_rate_mirror)
        && $stable(serial1_queue_ctrl_mirror))
        else $error("mirror changed without a write");

    // Serial 2 mirror holds when not written, reads included.
    ser2_hold_a: assert property (
        !serial2_queue_wr_i |=> $stable(serial2_queue_ctrl_mirror))
        else $error("serial 2 mirror changed without a write");

endmodule

// ===== sim/tb.sv
// Self-checking testbench for the runtime miscellaneous register slice.
`timescale 1ns/1ns
module tb;
    import misc_slice_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic ref_clk_i, rst_n_i, main_rst_n_i, hsel_i, hwrite_i, hready;
    logic [9:0] haddr_i;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic [31:0] hwdata_i, hrdata_o;
    logic hresp_o, irq_n, media_o, step_n, sel0_n, sel1_n, chg_n;
    logic [7:0] irq_src;
    logic [5:0] edge_pins;
    logic [2:0] mir_wr;
    logic [2:0][7:0] mir_data;
    int err_count = 0;
    int n_checks = 0;

    // The design under test, with hready looped back from its own output.
    misc_slice misc_slice_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .main_rst_n_i(main_rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hready), .hrdata_o(hrdata_o),
        .hreadyout_o(hready), .hresp_o(hresp_o),
        .general_pin_54_i(irq_src[0]), .general_pin_55_i(irq_src[1]),
        .general_pin_56_i(irq_src[2]), .general_pin_57_i(irq_src[3]),
        .fan_speed_sense_1_i(irq_src[6]), .fan_speed_sense_2_i(irq_src[7]),
        .grouped_mgmt_irq_out_n_o(irq_n),
        .general_pin_21_i(edge_pins[0]), .general_pin_22_i(edge_pins[1]),
        .general_pin_41_i(edge_pins[2]), .general_pin_43_i(edge_pins[3]),
        .general_pin_60_i(edge_pins[4]), .general_pin_61_i(edge_pins[5]),
        .head_step_pulse_n_i(step_n), .drive_select_0_n_i(sel0_n),
        .drive_select_1_n_i(sel1_n), .media_changed_input_n_i(chg_n),
        .media_changed_o(media_o), .rate_wr_i(mir_wr[0]), .rate_data_i(mir_data[0]),
        .serial1_queue_wr_i(mir_wr[1]), .serial1_queue_data_i(mir_data[1]),
        .serial2_queue_wr_i(mir_wr[2]), .serial2_queue_data_i(mir_data[2]));

    // ------------------------------------------------------------
    // Helper tasks
    // ------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Waits for a rising edge at which hready is sampled high; a hang ends the run.
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge ref_clk_i);
        while (hready !== 1'b1 && n < 100)
        begin
            @(posedge ref_clk_i);
            n++;
        end
        if (hready !== 1'b1)
        begin
            err_count++;
            stop_test();
        end
    endtask

    // One single word transfer: address phase, then data phase.
    task automatic bus_xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                            output logic [31:0] rd);
        @(posedge ref_clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {idx, 2'b00};
        htrans_i <= 2'b10;
        hwrite_i <= wr;
        hsize_i <= 3'b010;
        wait_ready();
        htrans_i <= 2'b00;
        hwdata_i <= {24'h000000, wd};
        wait_ready();
        rd = hrdata_o;
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        bus_xfer(idx, 1'b1, wd, d);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        bus_xfer(idx, 1'b0, 8'h00, d);
        check(name, d, {24'h000000, exp});
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset values of the enable, status and force registers and the idle interrupt output.
    task automatic test_reset();
        check("irq idle", {31'h0, irq_n}, 32'h1);
        rd_chk("enable reset", IDX_EN, EN_RESET);
        rd_chk("status reset", IDX_STS, 8'h00);
        rd_chk("force reset", IDX_FORCE, 8'h01);
    endtask

    // Each source alone, enabled and then masked; reserved enable bits route nothing.
    task automatic test_irq();
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(IDX_EN, 8'h01 << i);
            @(posedge ref_clk_i);
            irq_src <= 8'h01 << i;
            settle(2);
            check("irq enabled", {31'h0, irq_n}, {31'h0, ~EN_MASK[i]});
            wr_reg(IDX_EN, ~(8'h01 << i));
            settle(2);
            check("irq masked", {31'h0, irq_n}, 32'h1);
            @(posedge ref_clk_i);
            irq_src <= 8'h00;
        end
        wr_reg(IDX_EN, 8'hff);
        rd_chk("enable bits", IDX_EN, EN_MASK);
    endtask

    // Reserved places ignore writes and read zero; an unmapped place reads zero.
    task automatic test_reserved();
        wr_reg(IDX_RSVD_A, 8'hff);
        wr_reg(IDX_RSVD_B, 8'hff);
        rd_chk("reserved a", IDX_RSVD_A, 8'h00);
        rd_chk("reserved b", IDX_RSVD_B, 8'h00);
        check("hresp okay", {31'h0, hresp_o}, 32'h0);
        rd_chk("unmapped", 8'h22, 8'h00);
    endtask

    // Rising edges one pin at a time, partial clear, falling edges, full clear.
    task automatic test_status();
        logic [7:0] exp;
        exp = 8'h00;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge ref_clk_i);
            edge_pins <= edge_pins ^ (6'h01 << i);
            settle(3);
            exp = exp | (8'h01 << i);
            rd_chk("status rise", IDX_STS, exp);
        end
        wr_reg(IDX_STS, 8'h15);
        rd_chk("status partial clear", IDX_STS, 8'h2a);
        @(posedge ref_clk_i);
        edge_pins <= 6'h00;
        settle(3);
        rd_chk("status fall", IDX_STS, 8'h3f);
        wr_reg(IDX_STS, 8'hff);
        rd_chk("status cleared", IDX_STS, 8'h00);
    endtask

    // One step pulse while both selects are in the given state.
    task automatic step_pulse();
        @(posedge ref_clk_i);
        step_n <= 1'b0;
        @(posedge ref_clk_i);
        step_n <= 1'b1;
        settle(2);
    endtask

    // Forced media change: set only by software, cleared by step and select.
    task automatic test_force();
        wr_reg(IDX_FORCE, 8'h00);
        rd_chk("force no clear", IDX_FORCE, 8'h01);
        @(posedge ref_clk_i);
        sel0_n <= 1'b0;
        settle(2);
        check("media sel0", {31'h0, media_o}, 32'h1);
        step_pulse();
        rd_chk("force step 0", IDX_FORCE, 8'h00);
        check("media cleared", {31'h0, media_o}, 32'h0);
        wr_reg(IDX_FORCE, 8'h02);
        rd_chk("force set 1", IDX_FORCE, 8'h02);
        check("media other drive", {31'h0, media_o}, 32'h0);
        @(posedge ref_clk_i);
        sel0_n <= 1'b1;
        sel1_n <= 1'b0;
        settle(2);
        check("media sel1", {31'h0, media_o}, 32'h1);
        step_pulse();
        rd_chk("force step 1", IDX_FORCE, 8'h00);
        @(posedge ref_clk_i);
        chg_n <= 1'b0;
        settle(2);
        check("media input", {31'h0, media_o}, 32'h1);
        @(posedge ref_clk_i);
        chg_n <= 1'b1;
        sel1_n <= 1'b1;
        main_rst_n_i <= 1'b0;
        @(posedge ref_clk_i);
        main_rst_n_i <= 1'b1;
        rd_chk("force main reset", IDX_FORCE, 8'h01);
    endtask

    // Back-to-back control writes; the mirror keeps the last one across reads.
    task automatic test_mirror();
        logic [7:0] idx [3];
        logic [7:0] mask [3];
        idx = '{IDX_RATE, IDX_SER1, IDX_SER2};
        mask = '{RATE_MASK, QUEUE_MASK, QUEUE_MASK};
        for (int k = 0; k < 3; k++)
        begin
            @(posedge ref_clk_i);
            mir_wr[k] <= 1'b1;
            mir_data[k] <= 8'hff;
            @(posedge ref_clk_i);
            mir_wr[k] <= 1'b0;
            rd_chk("mirror full", idx[k], mask[k]);
            @(posedge ref_clk_i);
            mir_wr[k] <= 1'b1;
            mir_data[k] <= 8'h3c;
            @(posedge ref_clk_i);
            mir_data[k] <= 8'h5a;
            @(posedge ref_clk_i);
            mir_wr[k] <= 1'b0;
            rd_chk("mirror last", idx[k], 8'h5a & mask[k]);
            rd_chk("mirror reread", idx[k], 8'h5a & mask[k]);
        end
    endtask

    // ------------------------------------------------------------
    // Clock, reset and main sequence
    // ------------------------------------------------------------
    // Free-running 50 MHz clock.
    initial
    begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // Drives every input, resets, runs each scenario, then reports.
    initial
    begin
        {rst_n_i, main_rst_n_i, hsel_i, hwrite_i, haddr_i, htrans_i} <= '0;
        hsize_i <= 3'b010;
        hwdata_i <= 32'h00000000;
        {irq_src, edge_pins, mir_wr, mir_data} <= '0;
        {step_n, sel0_n, sel1_n, chg_n} <= 4'hf;
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        main_rst_n_i <= 1'b1;
        test_reset();
        test_irq();
        test_reserved();
        test_status();
        test_force();
        test_mirror();
        @(posedge ref_clk_i);
        edge_pins <= 6'h01;
        rst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd_chk("enable mid reset", IDX_EN, 8'h00);
        rd_chk("status mid reset", IDX_STS, 8'h00);
        stop_test();
    end
endmodule
